// [rtl/gdc_command_decoder.sv]
// Device-side instrument bus interface with command decoder
`timescale 1ns/1ps

module gdc_command_decoder
  import gdc_pkg::*;
#(
  parameter int DEF_ADDR = ADDR_RST
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Bus pins, active low, open drain
  input  wire logic [7:0] dioInN,
  output logic      [7:0] dioOutN,
  output logic      [7:0] dioOe,
  input  wire logic       atnInN,
  input  wire logic       renInN,
  input  wire logic       ifcInN,
  input  wire logic       davInN,
  output logic            davOutN,
  output logic            davOe,
  input  wire logic       nrfdInN,
  output logic            nrfdOutN,
  output logic            nrfdOe,
  input  wire logic       ndacInN,
  output logic            ndacOutN,
  output logic            ndacOe,
  input  wire logic       eoiInN,
  output logic            eoiOutN,
  output logic            eoiOe,
  output logic            srqOutN,
  output logic            srqOe,
  // Configuration
  input  wire logic [4:0] primaryAddr,
  // Message input
  output logic      [7:0] rxData,
  output logic            rxValid,
  output logic            rxEnd,
  // Message output
  input  wire logic [7:0] txData,
  input  wire logic       txEnd,
  input  wire logic       txValid,
  output logic            txTaken,
  // Service request and status
  input  wire logic       serviceReq,
  input  wire logic [7:0] statusByte,
  // Device events and state
  output logic            devClear,
  output logic            trigger,
  output logic            listenActive,
  output logic            talkActive,
  output logic            remoteMode,
  output logic            lockoutMode,
  output logic            serialPollMode,
  output logic [4:0]      curAddr
);

  if (DEF_ADDR < 0 || DEF_ADDR > int'(ADDR_MAX)) begin : g_chk
    $error("DEF_ADDR outside 0 to 30");
  end

  function automatic logic isCode(input logic [6:0] cmd, input logic [6:0] code);
    isCode = (cmd == code);
  endfunction : isCode

  gdc_state_s st_r;
  gdc_state_s st_nxt;

  // Positive-logic views of the synchronised pins
  logic [7:0] dioS;
  logic [6:0] cmdS;
  logic       atnS;
  logic       davS;
  logic       nrfdS;
  logic       ndacS;
  logic       renS;
  logic       ifcS;
  logic       eoiS;
  logic       accept;

  assign dioS   = ~st_r.sync2[7:0];
  assign cmdS   = dioS[6:0];
  assign atnS   = ~st_r.sync2[SY_ATN];
  assign davS   = ~st_r.sync2[SY_DAV];
  assign nrfdS  = ~st_r.sync2[SY_NRFD];
  assign ndacS  = ~st_r.sync2[SY_NDAC];
  assign renS   = ~st_r.sync2[SY_REN];
  assign ifcS   = ~st_r.sync2[SY_IFC];
  assign eoiS   = ~st_r.sync2[SY_EOI];
  assign accept = (st_r.ah == AH_READY) && davS;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.sync1    = {eoiInN, ifcInN, renInN, ndacInN, nrfdInN, davInN, atnInN, dioInN};
    st_nxt.sync2    = st_r.sync1;
    st_nxt.rxValid  = 1'b0;
    st_nxt.devClear = 1'b0;
    st_nxt.trigger  = 1'b0;
    st_nxt.txTaken  = 1'b0;
    st_nxt.srvPrev  = serviceReq;

    // Address change unaddresses the device
    if (primaryAddr <= ADDR_MAX && primaryAddr != st_r.addr) begin
      st_nxt.addr   = primaryAddr;
      st_nxt.listen = 1'b0;
      st_nxt.talk   = 1'b0;
    end

    // Remote enable dropped forces local
    if (!renS) begin
      st_nxt.remote  = 1'b0;
      st_nxt.lockout = 1'b0;
    end

    // Acceptor handshake
    case (st_r.ah)
      AH_IDLE: begin
        st_nxt.nrfdOe = 1'b0;
        st_nxt.ndacOe = 1'b0;
        if (atnS || st_r.listen) begin
          st_nxt.ndacOe = 1'b1;
          st_nxt.ah     = AH_READY;
        end
      end
      AH_READY: begin
        if (!(atnS || st_r.listen)) begin
          st_nxt.ndacOe = 1'b0;
          st_nxt.ah     = AH_IDLE;
        end else if (davS) begin
          st_nxt.nrfdOe = 1'b1;
          st_nxt.ndacOe = 1'b0;
          st_nxt.ah     = AH_HOLD;
          if (!atnS) begin
            st_nxt.rxData  = dioS;
            st_nxt.rxEnd   = eoiS;
            st_nxt.rxValid = 1'b1;
          end else if (isCode(cmdS, CMD_UNL)) begin
            st_nxt.listen = 1'b0;
          end else if (isCode(cmdS, CMD_UNT)) begin
            st_nxt.talk = 1'b0;
          end else if (cmdS[6:5] == GRP_LAG) begin
            if (cmdS[4:0] == st_r.addr) begin
              st_nxt.listen = 1'b1;
              st_nxt.talk   = 1'b0;
              if (renS) begin
                st_nxt.remote = 1'b1;
              end
            end
          end else if (cmdS[6:5] == GRP_TAG) begin
            if (cmdS[4:0] == st_r.addr) begin
              st_nxt.talk   = 1'b1;
              st_nxt.listen = 1'b0;
            end else begin
              st_nxt.talk = 1'b0;
            end
          end else if (cmdS[6:5] == GRP_SCG) begin
            st_nxt.ah = AH_HOLD;
          end else if (cmdS[4] == 1'b0) begin
            if (st_r.listen) begin
              case (cmdS)
                CMD_SDC: st_nxt.devClear = 1'b1;
                CMD_GTL: st_nxt.remote   = 1'b0;
                CMD_GET: st_nxt.trigger  = 1'b1;
                default: st_nxt.ah       = AH_HOLD;
              endcase
            end
          end else begin
            case (cmdS)
              CMD_DCL: st_nxt.devClear = 1'b1;
              CMD_LLO: st_nxt.lockout  = 1'b1;
              CMD_SPE: st_nxt.spoll    = 1'b1;
              CMD_SPD: st_nxt.spoll    = 1'b0;
              default: st_nxt.ah       = AH_HOLD;
            endcase
          end
        end
      end
      AH_HOLD: begin
        if (!davS) begin
          st_nxt.nrfdOe = 1'b0;
          if (atnS || st_r.listen) begin
            st_nxt.ndacOe = 1'b1;
            st_nxt.ah     = AH_READY;
          end else begin
            st_nxt.ah = AH_IDLE;
          end
        end
      end
      default: begin
        st_nxt.nrfdOe = 1'b0;
        st_nxt.ndacOe = 1'b0;
        st_nxt.ah     = AH_IDLE;
      end
    endcase

    // Source handshake
    case (st_r.sh)
      SH_IDLE: begin
        st_nxt.dioOe = 8'h00;
        st_nxt.davOe = 1'b0;
        st_nxt.eoiOe = 1'b0;
        if (st_r.talk && !atnS) begin
          st_nxt.settle = 6'h00;
          if (st_r.spoll) begin
            st_nxt.dioOe          = statusByte;
            st_nxt.dioOe[STB_RQS] = st_r.rqs;
            st_nxt.spByte         = 1'b1;
            st_nxt.txEnd          = 1'b0;
            st_nxt.sh             = SH_SETTLE;
          end else if (txValid) begin
            st_nxt.dioOe   = txData;
            st_nxt.spByte  = 1'b0;
            st_nxt.txEnd   = txEnd;
            st_nxt.txTaken = 1'b1;
            st_nxt.sh      = SH_SETTLE;
          end
        end
      end
      SH_SETTLE: begin
        if (st_r.settle != 6'(SETTLE_CYC - 1)) begin
          st_nxt.settle = st_r.settle + 6'h01;
        end else if (!nrfdS && ndacS) begin
          st_nxt.davOe = 1'b1;
          st_nxt.eoiOe = st_r.txEnd;
          st_nxt.sh    = SH_DAV;
        end
      end
      SH_DAV: begin
        if (!ndacS) begin
          st_nxt.davOe = 1'b0;
          st_nxt.eoiOe = 1'b0;
          st_nxt.dioOe = 8'h00;
          st_nxt.sh    = SH_IDLE;
          if (st_r.spByte && st_r.dioOe[STB_RQS]) begin
            st_nxt.rqs = 1'b0;
          end
        end
      end
      default: st_nxt.sh = SH_IDLE;
    endcase

    // Controller taking ATN aborts a source transfer
    if (atnS || !st_r.talk) begin
      st_nxt.dioOe = 8'h00;
      st_nxt.davOe = 1'b0;
      st_nxt.eoiOe = 1'b0;
      st_nxt.sh    = SH_IDLE;
    end

    // New service request; set wins over poll clear
    if (serviceReq && !st_r.srvPrev) begin
      st_nxt.rqs = 1'b1;
    end

    // Interface clear
    if (ifcS) begin
      st_nxt.listen = 1'b0;
      st_nxt.talk   = 1'b0;
      st_nxt.spoll  = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r       <= '0;
      st_r.sync1 <= {SY_W{1'b1}};
      st_r.sync2 <= {SY_W{1'b1}};
      st_r.addr  <= 5'(DEF_ADDR);
    end else begin
      st_r <= st_nxt;
    end
  end

  // Open-drain drivers pull low when enabled
  assign dioOutN        = 8'h00;
  assign davOutN        = 1'b0;
  assign nrfdOutN       = 1'b0;
  assign ndacOutN       = 1'b0;
  assign eoiOutN        = 1'b0;
  assign srqOutN        = 1'b0;
  assign dioOe          = st_r.dioOe;
  assign davOe          = st_r.davOe;
  assign nrfdOe         = st_r.nrfdOe;
  assign ndacOe         = st_r.ndacOe;
  assign eoiOe          = st_r.eoiOe;
  assign srqOe          = st_r.rqs;
  assign rxData         = st_r.rxData;
  assign rxValid        = st_r.rxValid;
  assign rxEnd          = st_r.rxEnd;
  assign txTaken        = st_r.txTaken;
  assign devClear       = st_r.devClear;
  assign trigger        = st_r.trigger;
  assign listenActive   = st_r.listen;
  assign talkActive     = st_r.talk;
  assign remoteMode     = st_r.remote;
  assign lockoutMode    = st_r.lockout;
  assign serialPollMode = st_r.spoll;
  assign curAddr        = st_r.addr;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic cmdQuiet;
  assign cmdQuiet = accept && atnS && !ifcS && (primaryAddr == st_r.addr);

  a_acg_unaddr: assert property (
    accept && atnS && !st_r.listen && isCode(cmdS, CMD_SDC) |=> !st_r.devClear)
    else $error("SDC obeyed while not listening");

  a_sdc_clear: assert property (
    accept && atnS && st_r.listen && isCode(cmdS, CMD_SDC) |=> st_r.devClear ##1 !st_r.devClear)
    else $error("SDC gave no one-cycle clear");

  a_gtl_local: assert property (
    accept && atnS && st_r.listen && isCode(cmdS, CMD_GTL) |=> !st_r.remote)
    else $error("GTL left device remote");

  a_get_trigger: assert property (
    accept && atnS && st_r.listen && isCode(cmdS, CMD_GET) |=> st_r.trigger)
    else $error("GET gave no trigger");

  a_mla_listen: assert property (
    cmdQuiet && cmdS == {GRP_LAG, st_r.addr} && st_r.addr != 5'h1F
    |=> st_r.listen && !st_r.talk)
    else $error("Own listen address not taken");

  a_mta_talk: assert property (
    cmdQuiet && cmdS == {GRP_TAG, st_r.addr} |=> st_r.talk && !st_r.listen)
    else $error("Own talk address not taken");

  a_scg_ignore: assert property (
    cmdQuiet && cmdS[6:5] == GRP_SCG |=> $stable(st_r.listen) && $stable(st_r.talk))
    else $error("Secondary byte changed addressing");

  a_unl_idle: assert property (
    accept && atnS && isCode(cmdS, CMD_UNL) |=> !st_r.listen)
    else $error("UNL left device listening");

  a_unt_idle: assert property (
    accept && atnS && isCode(cmdS, CMD_UNT) |=> !st_r.talk)
    else $error("UNT left device talking");

  a_dcl_clear: assert property (
    accept && atnS && isCode(cmdS, CMD_DCL) |=> st_r.devClear)
    else $error("DCL gave no clear");

  a_spe_mode: assert property (
    cmdQuiet && isCode(cmdS, CMD_SPE) |=> st_r.spoll)
    else $error("SPE did not enable serial poll");

  a_talk_drive: assert property (
    st_r.davOe |-> $past(st_r.talk) && !$past(atnS))
    else $error("Data valid driven while not talker");

  a_data_listen: assert property (
    st_r.rxValid |-> $past(st_r.listen) && !$past(atnS))
    else $error("Data byte taken while not listener");

  a_srq_line: assert property (
    serviceReq && !st_r.srvPrev |=> st_r.rqs [*2])
    else $error("Service request not raised");

endmodule : gdc_command_decoder

// [rtl/gdc_pkg.sv]
// Constants and types for the instrument bus command decoder
//
// How it works
// - Addressed commands obeyed only while listen-addressed
// - Listened SDC 04 raises device clear
// - Listened GTL 01 returns to local
// - Listened GET 08 raises trigger
// - Address ORed into 20 makes listener
// - Address ORed into 40 makes talker
// - Secondary bytes 60 to 7F ignored
// - UNL 3F always clears listener
// - UNT 5F clears talker
// - ATN-false bytes go to message input
// - DCL 14 clears without addressing
// - Decode LLO 11, SPE 18, SPD 19
// - Source data only while addressed talker
// - Own listen address drops talker
// - Accept data only while addressed listener
// - Own talk address drops listener
// - No parallel poll; configure commands ignored
// - Request service, report status in poll
// - Remote when listen-addressed with REN, local on GTL
// - Primary address limited to 0 through 30
package gdc_pkg;

  // Clock and timing
  localparam int          CLK_NS      = 50;
  localparam int          SETTLE_NS   = 2000;
  localparam int          SETTLE_CYC  = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  // Address limits and reset value
  localparam logic [4:0]  ADDR_MAX    = 5'h1E;
  localparam int          ADDR_RST    = 7;

  // Multiline command codes, seven bits
  localparam logic [6:0]  CMD_GTL     = 7'h01;
  localparam logic [6:0]  CMD_SDC     = 7'h04;
  localparam logic [6:0]  CMD_GET     = 7'h08;
  localparam logic [6:0]  CMD_LLO     = 7'h11;
  localparam logic [6:0]  CMD_DCL     = 7'h14;
  localparam logic [6:0]  CMD_SPE     = 7'h18;
  localparam logic [6:0]  CMD_SPD     = 7'h19;
  localparam logic [6:0]  CMD_UNL     = 7'h3F;
  localparam logic [6:0]  CMD_UNT     = 7'h5F;

  // Command groups in bits 6:5
  localparam logic [1:0]  GRP_CMD     = 2'h0;
  localparam logic [1:0]  GRP_LAG     = 2'h1;
  localparam logic [1:0]  GRP_TAG     = 2'h2;
  localparam logic [1:0]  GRP_SCG     = 2'h3;

  // Status byte service request bit
  localparam int          STB_RQS     = 6;

  // Synchroniser vector layout
  localparam int          SY_ATN      = 8;
  localparam int          SY_DAV      = 9;
  localparam int          SY_NRFD     = 10;
  localparam int          SY_NDAC     = 11;
  localparam int          SY_REN      = 12;
  localparam int          SY_IFC      = 13;
  localparam int          SY_EOI      = 14;
  localparam int          SY_W        = 15;

  typedef enum logic [1:0] {
    AH_IDLE  = 2'b00,
    AH_READY = 2'b01,
    AH_HOLD  = 2'b10
  } gdc_ah_e;

  typedef enum logic [1:0] {
    SH_IDLE   = 2'b00,
    SH_SETTLE = 2'b01,
    SH_DAV    = 2'b10
  } gdc_sh_e;

  typedef struct packed {
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    gdc_ah_e         ah;
    gdc_sh_e         sh;
    logic [4:0]      addr;
    logic            listen;
    logic            talk;
    logic            remote;
    logic            lockout;
    logic            spoll;
    logic            rqs;
    logic            srvPrev;
    logic [5:0]      settle;
    logic            spByte;
    logic            txEnd;
    logic [7:0]      rxData;
    logic            rxValid;
    logic            rxEnd;
    logic            devClear;
    logic            trigger;
    logic            txTaken;
    logic [7:0]      dioOe;
    logic            davOe;
    logic            nrfdOe;
    logic            ndacOe;
    logic            eoiOe;
  } gdc_state_s;

endpackage : gdc_pkg

// [bench/gdc_bus_controller.sv]
// Behavioural bus controller facing the command decoder
`timescale 1ns/1ps

module gdc_bus_controller (
  // Clock
  input  wire logic       clk,
  // Device drive enables
  input  wire logic [7:0] dioOe,
  input  wire logic       davOe,
  input  wire logic       nrfdOe,
  input  wire logic       ndacOe,
  input  wire logic       eoiOe,
  // Open drain wires as seen on the bus
  output logic      [7:0] dioInN,
  output logic            atnInN,
  output logic            davInN,
  output logic            nrfdInN,
  output logic            ndacInN,
  output logic            eoiInN,
  // Byte taken from a talker
  output logic      [8:0] got,
  output logic            gotV
);
  logic [7:0] dioCtl;
  logic       davCtl;
  logic       nrfdCtl;
  logic       ndacCtl;
  logic       eoiCtl;
  int         lag;

  // Pull-ups: a line is low when any party pulls it
  assign dioInN  = dioCtl & ~dioOe;
  assign davInN  = davCtl & ~davOe;
  assign nrfdInN = nrfdCtl & ~nrfdOe;
  assign ndacInN = ndacCtl & ~ndacOe;
  assign eoiInN  = eoiCtl & ~eoiOe;

  initial begin
    {dioCtl, atnInN, davCtl, nrfdCtl, ndacCtl, eoiCtl} = 13'h1FFF;
    lag  = 0;
    got  = 9'h000;
    gotV = 1'b0;
  end

  // Source one byte as controller
  task sendByte(input logic atn, input logic [7:0] d, input logic eoi);
    int n;
    atnInN = ~atn;
    dioCtl = ~d;
    eoiCtl = ~eoi;
    repeat (4 + lag) @(negedge clk);
    for (n = 0; n < 20 && nrfdInN !== 1'b1; n++) @(negedge clk);
    davCtl = 1'b0;
    repeat (4 + lag) @(negedge clk);
    for (n = 0; n < 20 && ndacInN !== 1'b1; n++) @(negedge clk);
    davCtl = 1'b1;
    dioCtl = 8'hFF;
    eoiCtl = 1'b1;
    repeat (4) @(negedge clk);
  endtask : sendByte

  // Accept one byte from a talker
  task rcvByte;
    int n;
    atnInN  = 1'b1;
    ndacCtl = 1'b0;
    for (n = 0; n < 200 && davInN !== 1'b0; n++) @(negedge clk);
    repeat (lag) @(negedge clk);
    got  = {~eoiInN, ~dioInN};
    gotV = 1'b1;
    @(negedge clk);
    gotV    = 1'b0;
    ndacCtl = 1'b1;
    for (n = 0; n < 20 && davInN !== 1'b1; n++) @(negedge clk);
    repeat (2) @(negedge clk);
  endtask : rcvByte
endmodule : gdc_bus_controller

// [bench/test_gdc_command_decoder.sv]
// Self-checking bench for the command decoder
`timescale 1ns/1ps

module test_gdc_command_decoder import gdc_pkg::*;;
  logic clk, resetn, renInN, ifcInN, txEnd, txValid, txTaken, serviceReq, srqOe;
  logic davOutN, nrfdOutN, ndacOutN, eoiOutN, srqOutN;
  logic [5:0]  pins;
  logic atnInN, davInN, nrfdInN, ndacInN, eoiInN, davOe, nrfdOe, ndacOe, eoiOe;
  logic rxValid, rxEnd, devClear, trigger, gotV;
  logic listenActive, talkActive, remoteMode, lockoutMode, serialPollMode;
  logic [7:0]  dioInN, dioOutN, dioOe, rxData, txData, statusByte, d;
  logic [4:0]  primaryAddr, curAddr;
  logic [8:0]  got;
  logic [10:0] q[$];
  int          n_errors, n_tests, seed, i, n, cyc;

  gdc_command_decoder i_gdc_command_decoder (.clk, .resetn, .dioInN, .dioOutN, .dioOe,
    .atnInN, .renInN, .ifcInN, .davInN, .davOutN, .davOe, .nrfdInN, .nrfdOutN,
    .nrfdOe, .ndacInN, .ndacOutN, .ndacOe, .eoiInN, .eoiOutN, .eoiOe, .srqOutN,
    .srqOe, .primaryAddr, .rxData, .rxValid, .rxEnd, .txData, .txEnd, .txValid, .txTaken,
    .serviceReq, .statusByte, .devClear, .trigger, .listenActive, .talkActive, .remoteMode,
    .lockoutMode, .serialPollMode, .curAddr);

  gdc_bus_controller i_gdc_bus_controller (.clk, .dioOe, .davOe, .nrfdOe, .ndacOe, .eoiOe,
    .dioInN, .atnInN, .davInN, .nrfdInN, .ndacInN, .eoiInN, .got, .gotV);

  initial clk = 1'b0;
  always #25 clk = ~clk;

  task check(input string nm, input logic [10:0] seen, input logic [10:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task cmp(input logic [10:0] v);
    if (q.size() == 0) check("unexpected event", v, ~v);
    else check("event", v, q.pop_front());
  endtask : cmp

  // Listen, talk, remote, lockout, poll
  task st(input logic [4:0] e);
    check("state", {6'h00, listenActive, talkActive, remoteMode, lockoutMode,
      serialPollMode}, {6'h00, e});
  endtask : st

  task sb(input logic a, input logic [7:0] v, input logic e = 1'b0);
    i_gdc_bus_controller.sendByte(a, v, e);
  endtask : sb

  // Command byte with ATN true
  task sc(input logic [6:0] c);
    sb(1'b1, {1'b0, c});
  endtask : sc

  task test_done;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // Result watcher
  always @(posedge clk) begin
    if (rxValid === 1'b1) cmp({2'h0, rxEnd, rxData});
    if (devClear === 1'b1) cmp(11'h200);
    if (trigger === 1'b1) cmp(11'h400);
    if (gotV === 1'b1) cmp({2'h3, got});
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      test_done;
    end
  end

  initial begin
    seed = 57;
    {resetn, txEnd, txValid, serviceReq} = 4'h0;
    renInN = 1'b1;
    ifcInN = 1'b1;
    primaryAddr = 5'h07;
    txData = 8'h00;
    statusByte = 8'h00;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    check("addr", {6'h00, curAddr}, 11'h007);
    pins = {|dioOutN, davOutN, nrfdOutN, ndacOutN, eoiOutN, srqOutN};
    check("pin level", {5'h00, pins}, 11'h000);
    sc(CMD_GET);
    sc(CMD_SDC);
    renInN = 1'b0;
    sc(CMD_UNL);
    sb(1'b1, 8'h27);
    st(5'h14);
    q.push_back(11'h200);
    sc(CMD_SDC);
    q.push_back(11'h400);
    sc(CMD_GET);
    sb(1'b1, 8'h67);
    sb(1'b1, 8'h05);
    sb(1'b1, 8'h15);
    st(5'h14);
    sc(CMD_GTL);
    st(5'h10);
    for (i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      q.push_back({2'h0, i == 3, d});
      sb(1'b0, d, i == 3);
    end
    sb(1'b1, 8'h47);
    st(5'h08);
    sb(1'b0, 8'h3C);
    i_gdc_bus_controller.lag = 3;
    d = 8'($random(seed));
    q.push_back({3'h7, d});
    txData = d;
    txEnd = 1'b1;
    txValid = 1'b1;
    fork
      i_gdc_bus_controller.rcvByte();
      begin
        for (n = 0; n < 100 && txTaken !== 1'b1; n++) @(negedge clk);
        check("taken", {10'h000, txTaken}, 11'h001);
        txValid = 1'b0;
      end
    join
    i_gdc_bus_controller.lag = 0;
    sb(1'b1, 8'h27);
    st(5'h14);
    sc(CMD_UNL);
    st(5'h04);
    sb(1'b1, 8'h47);
    sc(CMD_UNT);
    st(5'h04);
    q.push_back(11'h200);
    sc(CMD_DCL);
    sc(CMD_LLO);
    check("lockout", {10'h000, lockoutMode}, 11'h001);
    statusByte = 8'($random(seed)) & 8'hBF;
    serviceReq = 1'b1;
    repeat (2) @(negedge clk);
    check("srq", {10'h000, srqOe}, 11'h001);
    sc(CMD_SPE);
    check("poll", {10'h000, serialPollMode}, 11'h001);
    sb(1'b1, 8'h47);
    q.push_back({3'h6, statusByte | 8'h40});
    i_gdc_bus_controller.rcvByte();
    check("srq", {10'h000, srqOe}, 11'h000);
    serviceReq = 1'b0;
    sc(CMD_SPD);
    check("poll", {10'h000, serialPollMode}, 11'h000);
    primaryAddr = 5'h1F;
    repeat (4) @(negedge clk);
    check("addr", {6'h00, curAddr}, 11'h007);
    primaryAddr = 5'h1E;
    repeat (4) @(negedge clk);
    check("addr", {6'h00, curAddr}, 11'h01E);
    sc(CMD_UNL);
    sb(1'b1, 8'h3E);
    check("listen", {10'h000, listenActive}, 11'h001);
    st(5'h16);
    renInN = 1'b1;
    repeat (4) @(negedge clk);
    st(5'h10);
    ifcInN = 1'b0;
    repeat (4) @(negedge clk);
    ifcInN = 1'b1;
    st(5'h00);
    repeat (5) @(negedge clk);
    check("queue", 11'(q.size()), 11'h000);
    test_done;
  end
endmodule : test_gdc_command_decoder
